// >>> testbench/spi_host_model.sv
`timescale 1ns/1ps

// host side of the serial port: one frame per call, sclk idles low
module spi_host_model (
  input  wire logic clk_in,
  input  wire logic sdo_in,
  input  wire logic sdio_in,
  input  wire logic sdio_oe_in,
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      sdio_out
);
  // the port samples sclk through a synchroniser, so phases stay long
  localparam int HALF = 6;

  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sdio_out = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic xfer(input logic rd, input logic [6:0] a,
                      input logic [7:0] wd, input logic lsb,
                      input logic bidir, output logic [7:0] q,
                      output logic oe_seen);
    logic [15:0] frm;
    int          k;
    frm = {rd, a, wd};
    q = 8'h00;
    oe_seen = 1'b0;
    cs_n_out = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      k = lsb ? ((i < 8) ? 8 + i : i - 8) : 15 - i;
      sclk_out = 1'b0;
      // released during read data: the line shows junk, not the last bit
      if (rd && i >= 8)
        sdio_out = ~sdio_out;
      else
        sdio_out = frm[k];
      step(HALF);
      if (rd && i >= 8)
      begin
        q[k] = bidir ? sdio_in : sdo_in;
        oe_seen = oe_seen | sdio_oe_in;
      end
      sclk_out = 1'b1;
      step(HALF);
    end
    cs_n_out = 1'b1;
    sdio_out = ~sdio_out;
    step(HALF);
    sclk_out = 1'b0;
    step(HALF);
  endtask
endmodule

// >>> testbench/tb_dac_config_comm_format_regs.sv
`timescale 1ns/1ps
`include "dac_cfg_map.svh"

module tb_dac_config_comm_format_regs;
  logic        clk_in, reset_in, cs_n, sclk, host_sdio, sdio_w;
  logic        sdio_o, sdio_oe, sdo, irq, invalid, q_first, dev_reset;
  logic        pll_lock, sync_lock, clk_ready, fifo_done;
  logic        pd_i, pd_q, pd_rx, pd_aux, oe_seen, lsb, bidir;
  logic [1:0]  width;
  logic [7:0]  rd, m;
  logic [31:0] pins, word, rev;
  int          n_fail, checked;
  logic [3:0]  ev_step [6] = '{4'h8, 4'h0, 4'h4, 4'h0, 4'h2, 4'h3};
  int          ev_bit [6] = '{6, 7, 4, 5, 3, 2};
  logic [6:0]  adr [4] = '{`ADDR_POWER, `ADDR_FORMAT, `ADDR_IEN1, 7'h02};
  logic [7:0]  msk [4] = '{`PWR_MASK, `FMT_MASK, `EV_MASK, 8'h00};

  // the dut wins the shared data line whenever it drives
  assign sdio_w = sdio_oe ? sdio_o : host_sdio;

  initial clk_in = 1'b0;
  always #5 clk_in = ~clk_in;

  spi_host_model u_host (
    .clk_in     (clk_in),
    .sdo_in     (sdo),
    .sdio_in    (sdio_w),
    .sdio_oe_in (sdio_oe),
    .cs_n_out   (cs_n),
    .sclk_out   (sclk),
    .sdio_out   (host_sdio)
  );

  dac_config_comm_format_regs u_dut (
    .clk_in            (clk_in),
    .reset_in          (reset_in),
    .spi_cs_n_in       (cs_n),
    .spi_sclk_in       (sclk),
    .sdio_in           (sdio_w),
    .sdio_out          (sdio_o),
    .sdio_oe_out       (sdio_oe),
    .sdo_out           (sdo),
    .pll_lock_in       (pll_lock),
    .sync_lock_in      (sync_lock),
    .clk_ready_in      (clk_ready),
    .fifo_sync_done_in (fifo_done),
    .data_pins_in      (pins),
    .data_word_out     (word),
    .data_invalid_out  (invalid),
    .q_first_out       (q_first),
    .bus_width_out     (width),
    .dev_reset_out     (dev_reset),
    .pd_i_out          (pd_i),
    .pd_q_out          (pd_q),
    .pd_rx_out         (pd_rx),
    .pd_aux_out        (pd_aux),
    .irq_out           (irq)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    chk_pin({24'h0, got}, {24'h0, exp});
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, lsb, bidir, rd, oe_seen);
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    u_host.xfer(1'b1, a, 8'h00, lsb, bidir, rd, oe_seen);
    chk_reg(rd, exp);
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk_in);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    reset_in = 1'b1;
    pins = 32'h0;
    {pll_lock, sync_lock, clk_ready, fifo_done} = 4'h0;
    {lsb, bidir} = 2'b00;
    n_fail = 0;
    checked = 0;
    tick(10);
    reset_in = 1'b0;
    tick(5);
    chk_pin({23'h0, pd_i, pd_q, pd_rx, pd_aux, dev_reset, irq, invalid, width},
            32'h0);
    rdchk(`ADDR_COMM, `RST_COMM);
    foreach (adr[i])
    begin
      rdchk(adr[i], 8'h00);
      wr(adr[i], 8'hff);
      rdchk(adr[i], msk[i]);
      wr(adr[i], 8'h00);
    end
    for (int b = 4; b < 8; b++)
    begin
      m = 8'h01 << b;
      wr(`ADDR_POWER, m);
      chk_pin({pd_i, pd_q, pd_rx, pd_aux}, m[7:4]);
    end
    wr(`ADDR_POWER, 8'h00);
    for (int w = 0; w < 4; w++)
    begin
      m = {1'b0, w[0], 4'h0, w[1:0]};
      wr(`ADDR_FORMAT, m);
      chk_pin({q_first, width, invalid}, {m[6], m[1:0], &m[1:0]});
    end
    // dual-word mode: offset binary flips the top bit of each half
    pins = 32'h1234_c001;
    rev = {<<{pins}};
    wr(`ADDR_FORMAT, 8'h00);
    chk_pin(word, pins);
    wr(`ADDR_FORMAT, 8'h80);
    chk_pin(word, pins ^ 32'h8000_8000);
    wr(`ADDR_FORMAT, 8'h20);
    chk_pin(word, rev);
    wr(`ADDR_FORMAT, 8'h03);
    chk_pin(word, 32'h0);
    // word and byte modes map only the active low pins
    wr(`ADDR_FORMAT, 8'h21);
    chk_pin(word, {16'h0000, rev[31:16]});
    wr(`ADDR_FORMAT, 8'h81);
    chk_pin(word, {16'h0000, pins[15:0] ^ 16'h8000});
    wr(`ADDR_FORMAT, 8'h22);
    chk_pin(word, {24'h00_0000, rev[31:24]});
    for (int s = 0; s < 6; s++)
    begin
      m = 8'h01 << ev_bit[s];
      wr(`ADDR_IEN1, `EV_MASK & ~m);
      {pll_lock, sync_lock, clk_ready, fifo_done} = ev_step[s];
      tick(8);
      rdchk(`ADDR_FLAG1, m);
      chk_pin(irq, 1'b0);
      wr(`ADDR_IEN1, m);
      chk_pin(irq, 1'b1);
      wr(`ADDR_FLAG1, m);
      chk_pin(irq, 1'b0);
    end
    // lost flag must survive the pll coming back
    pll_lock = 1'b1;
    tick(8);
    pll_lock = 1'b0;
    tick(8);
    pll_lock = 1'b1;
    tick(8);
    rdchk(`ADDR_FLAG1, 8'hc0);
    rdchk(`ADDR_POWER, 8'h01);
    pll_lock = 1'b0;
    wr(`ADDR_POWER, 8'h30);
    wr(`ADDR_COMM, 8'h20);
    chk_pin({dev_reset, pd_rx, pd_aux}, 3'b100);
    wr(`ADDR_POWER, 8'hf0);
    rdchk(`ADDR_POWER, 8'h00);
    rdchk(`ADDR_FLAG1, 8'h00);
    rdchk(`ADDR_COMM, 8'h20);
    wr(`ADDR_COMM, 8'h00);
    chk_pin(dev_reset, 1'b0);
    wr(`ADDR_POWER, 8'h30);
    rdchk(`ADDR_POWER, 8'h30);
    wr(`ADDR_COMM, 8'h80);
    bidir = 1'b1;
    rdchk(`ADDR_POWER, 8'h30);
    chk_pin(oe_seen, 1'b1);
    wr(`ADDR_COMM, 8'hc0);
    lsb = 1'b1;
    wr(`ADDR_IEN1, 8'h84);
    rdchk(`ADDR_IEN1, 8'h84);
    rdchk(`ADDR_COMM, 8'hc0);
    wr(`ADDR_COMM, 8'h00);
    {lsb, bidir} = 2'b00;
    rdchk(`ADDR_IEN1, 8'h84);
    chk_pin(oe_seen, 1'b0);
    print_verdict();
  end
endmodule

// >>> verilog/dac_cfg_map.svh
`ifndef DAC_CFG_MAP_SVH
`define DAC_CFG_MAP_SVH

// register offsets on the serial port
`define ADDR_COMM       7'h00
`define ADDR_POWER      7'h01
`define ADDR_FORMAT     7'h03
`define ADDR_IEN1       7'h04
`define ADDR_FLAG1      7'h06

// serial_comm_config fields
`define COMM_SDIO_BIDIR 7
`define COMM_LSB_FIRST  6
`define COMM_SOFT_RST   5
`define COMM_MASK       8'he0

// power_control fields
`define PWR_PD_I        7
`define PWR_PD_Q        6
`define PWR_PD_RX       5
`define PWR_PD_AUX      4
`define PWR_LOCK_STAT   0
`define PWR_MASK        8'hf0

// input_data_format fields
`define FMT_BINARY      7
`define FMT_Q_FIRST     6
`define FMT_MSB_SWAP    5
`define FMT_MASK        8'he3
`define FMT_W32         2'b00
`define FMT_W16         2'b01
`define FMT_W8          2'b10

// interrupt_enable_first and event flag fields
`define EV_PLL_LOST     7
`define EV_PLL_LOCK     6
`define EV_SYNC_LOST    5
`define EV_SYNC_LOCK    4
`define EV_CLK_READY    3
`define EV_FIFO_DONE    2
`define EV_MASK         8'hfc

// reset values
`define RST_COMM        8'h00
`define RST_POWER       8'h00
`define RST_FORMAT      8'h00
`define RST_IEN1        8'h00
`define RST_FLAG1       8'h00

// serial frame: one instruction byte, one data byte
`define SPI_BYTE_BITS   8

`endif

// >>> verilog/dac_cfg_pkg.sv
package dac_cfg_pkg;

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_INSTR,
    ST_DATA
  } spi_state_e;

  typedef logic [7:0] reg_byte_t;

endpackage

// >>> verilog/dac_config_comm_format_regs.sv
`timescale 1ns/1ps
`include "dac_cfg_map.svh"

// What this block does
// [R1] SDIO bit: input-only or bidirectional data pin
// [R2] bit order: MSB first or LSB first
// [R3] soft reset held while bit stays set
// [R4] independent power-down of I and Q converters
// [R5] power-down data receiver and auxiliary ADC
// [R6] input samples two's complement or straight binary at bus widths 32 and 16
// [R7] pairing order: I first or Q first
// [R8] swap reverses input pin bit order
// [R9] bus width: 32, 16, 8 bits, 11 invalid
// [R10] enable interrupt on PLL lock lost
// [R11] enable interrupt on PLL locked
// [R12] enable interrupt on sync lock lost
// [R13] enable interrupt on sync lock achieved
// [R14] enable interrupt on clock generation ready
// [R15] enable interrupt on soft FIFO reset done
// [R16] PLL lock lost flag latches when set
// [R17] interrupt when any enabled flag set
module dac_config_comm_format_regs
  import dac_cfg_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        spi_cs_n_in,
  input  wire logic        spi_sclk_in,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe_out,
  output logic             sdo_out,
  input  wire logic        pll_lock_in,
  input  wire logic        sync_lock_in,
  input  wire logic        clk_ready_in,
  input  wire logic        fifo_sync_done_in,
  input  wire logic [31:0] data_pins_in,
  output logic      [31:0] data_word_out,
  output logic             data_invalid_out,
  output logic             q_first_out,
  output logic      [1:0]  bus_width_out,
  output logic             dev_reset_out,
  output logic             pd_i_out,
  output logic             pd_q_out,
  output logic             pd_rx_out,
  output logic             pd_aux_out,
  output logic             irq_out
);

  reg_byte_t  comm_r;
  reg_byte_t  power_r;
  reg_byte_t  fmt_r;
  reg_byte_t  ien_r;
  reg_byte_t  flag_r;
  spi_state_e state_r;
  logic [2:0] bit_cnt_r;
  reg_byte_t  shift_r;
  logic       rd_r;
  logic [6:0] addr_r;
  logic       sclk_d_r;
  logic [3:0] ev_d_r;

  logic       cs_n_s;
  logic       sclk_s;
  logic       sdi_s;
  logic [3:0] ev_s;
  logic [31:0] data_s;

  logic       sclk_rise;
  logic       sclk_fall;
  logic       lsb_first;
  logic       soft_rst;
  reg_byte_t  shift_nxt;
  reg_byte_t  rd_byte;
  logic       wr_stb;
  reg_byte_t  flag_set;
  reg_byte_t  flag_clr;

  pin_sync #(.WIDTH(3), .INIT_VAL(3'b100)) u_spi_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .d_in     ({spi_cs_n_in, spi_sclk_in, sdio_in}),
    .q_out    ({cs_n_s, sclk_s, sdi_s})
  );

  pin_sync #(.WIDTH(4), .INIT_VAL(4'h0)) u_ev_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .d_in     ({pll_lock_in, sync_lock_in, clk_ready_in, fifo_sync_done_in}),
    .q_out    (ev_s)
  );

  pin_sync #(.WIDTH(32), .INIT_VAL(32'h0000_0000)) u_data_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .d_in     (data_pins_in),
    .q_out    (data_s)
  );

  assign lsb_first = comm_r[`COMM_LSB_FIRST];
  assign soft_rst  = comm_r[`COMM_SOFT_RST];
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;

  // both ends assemble bytes in the same selected order
  assign shift_nxt = lsb_first ? {sdi_s, shift_r[7:1]}   // [R2]
                               : {shift_r[6:0], sdi_s};  // [R2]

  assign wr_stb = sclk_rise && !cs_n_s && state_r == ST_DATA &&
                  bit_cnt_r == 3'd7 && !rd_r;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      sclk_d_r <= 1'b0;
    else
      sclk_d_r <= sclk_s;
  end

  // serial frame: instruction byte (read bit, 7-bit address), data byte
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 3'd0;
      shift_r   <= 8'h00;
      rd_r      <= 1'b0;
      addr_r    <= 7'h00;
    end
    else if (cs_n_s)
    begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 3'd0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          state_r <= ST_INSTR;
        ST_INSTR:
        begin
          if (sclk_rise)
          begin
            shift_r   <= shift_nxt;
            bit_cnt_r <= bit_cnt_r + 3'd1;
            if (bit_cnt_r == 3'd7)
            begin
              rd_r    <= shift_nxt[7];
              addr_r  <= shift_nxt[6:0];
              state_r <= ST_DATA;
            end
          end
        end
        ST_DATA:
        begin
          if (sclk_rise)
          begin
            shift_r   <= shift_nxt;
            bit_cnt_r <= bit_cnt_r + 3'd1;
            if (bit_cnt_r == 3'd7)
              state_r <= ST_IDLE;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // readback multiplexer; unmapped offsets read as zero
  always_comb
  begin
    case (addr_r)
      `ADDR_COMM:   rd_byte = comm_r;
      `ADDR_POWER:  rd_byte = {power_r[7:1], ev_s[3]};
      `ADDR_FORMAT: rd_byte = fmt_r;
      `ADDR_IEN1:   rd_byte = ien_r;
      `ADDR_FLAG1:  rd_byte = flag_r;
      default:      rd_byte = 8'h00;
    endcase
  end

  // read data changes on falling sclk so the host samples it on rising
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sdio_out    <= 1'b0;
      sdio_oe_out <= 1'b0;
      sdo_out     <= 1'b0;
    end
    else if (cs_n_s || state_r != ST_DATA || !rd_r)
    begin
      sdio_oe_out <= 1'b0;
      sdo_out     <= 1'b0;
    end
    else if (sclk_fall)
    begin
      sdo_out     <= lsb_first ? rd_byte[bit_cnt_r]             // [R2]
                               : rd_byte[3'd7 - bit_cnt_r];     // [R2]
      sdio_out    <= lsb_first ? rd_byte[bit_cnt_r]
                               : rd_byte[3'd7 - bit_cnt_r];
      sdio_oe_out <= comm_r[`COMM_SDIO_BIDIR];                  // [R1]
    end
  end

  // comm register survives the soft reset so software can release it
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      comm_r <= `RST_COMM;
    else if (wr_stb && addr_r == `ADDR_COMM)
      comm_r <= shift_nxt & `COMM_MASK;                         // [R1]
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in || soft_rst)                                   // [R3]
    begin
      power_r <= `RST_POWER;
      fmt_r   <= `RST_FORMAT;
      ien_r   <= `RST_IEN1;
    end
    else if (wr_stb)
    begin
      case (addr_r)
        `ADDR_POWER:  power_r <= shift_nxt & `PWR_MASK;         // [R4] [R5]
        `ADDR_FORMAT: fmt_r   <= shift_nxt & `FMT_MASK;         // [R6] [R9]
        `ADDR_IEN1:   ien_r   <= shift_nxt & `EV_MASK;    // [R10] [R11] [R12]
        default:      power_r <= power_r;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      ev_d_r <= 4'h0;
    else
      ev_d_r <= ev_s;
  end

  always_comb
  begin
    flag_set = 8'h00;
    flag_set[`EV_PLL_LOST]  = ev_d_r[3] & ~ev_s[3];             // [R16]
    flag_set[`EV_PLL_LOCK]  = ev_s[3] & ~ev_d_r[3];
    flag_set[`EV_SYNC_LOST] = ev_d_r[2] & ~ev_s[2];
    flag_set[`EV_SYNC_LOCK] = ev_s[2] & ~ev_d_r[2];
    flag_set[`EV_CLK_READY] = ev_s[1] & ~ev_d_r[1];
    flag_set[`EV_FIFO_DONE] = ev_s[0] & ~ev_d_r[0];
    flag_clr = (wr_stb && addr_r == `ADDR_FLAG1) ? shift_nxt : 8'h00;
  end

  // write one clears; a new event in the same cycle wins over the clear
  always_ff @(posedge clk_in)
  begin
    if (reset_in || soft_rst)
      flag_r <= `RST_FLAG1;
    else
      flag_r <= ((flag_r & ~flag_clr) | flag_set) & `EV_MASK;   // [R16]
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(flag_r & ien_r);          // [R17] [R13] [R14] [R15]
  end

  // pin mapping within the active width, then offset-binary correction;
  // byte mode leaves the sign bit to the sample assembler downstream
  function automatic logic [31:0] map_word(input logic [31:0] d,
                                           input reg_byte_t   f);
    logic [31:0] r;
    logic [31:0] w;
    // the top of the full reversal holds the reversed low pins
    r = {<<{d}};
    case (f[1:0])
      `FMT_W32: w = f[`FMT_MSB_SWAP] ? r : d;
      `FMT_W16: w = {16'h0000, f[`FMT_MSB_SWAP] ? r[31:16] : d[15:0]};
      `FMT_W8:  w = {24'h00_0000, f[`FMT_MSB_SWAP] ? r[31:24] : d[7:0]};
      default:  w = 32'h0000_0000;
    endcase
    if (f[`FMT_BINARY] && f[1:0] == `FMT_W32)
      w = w ^ 32'h8000_8000;
    else if (f[`FMT_BINARY] && f[1:0] == `FMT_W16)
      w = w ^ 32'h0000_8000;
    return w;
  endfunction

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      data_word_out    <= 32'h0000_0000;
      data_invalid_out <= 1'b0;
      dev_reset_out    <= 1'b0;
      q_first_out      <= 1'b0;
      bus_width_out    <= `FMT_W32;
      {pd_i_out, pd_q_out}    <= 2'b00;
      {pd_rx_out, pd_aux_out} <= 2'b00;
    end
    else
    begin
      data_word_out    <= map_word(data_s, fmt_r);              // [R6] [R8]
      data_invalid_out <= fmt_r[1:0] == 2'b11;                  // [R9]
      dev_reset_out    <= soft_rst;                             // [R3]
      q_first_out      <= fmt_r[`FMT_Q_FIRST];                  // [R7]
      bus_width_out    <= fmt_r[1:0];                           // [R9]
      {pd_i_out, pd_q_out}    <= power_r[`PWR_PD_I:`PWR_PD_Q];  // [R4]
      {pd_rx_out, pd_aux_out} <= power_r[`PWR_PD_RX:`PWR_PD_AUX]; // [R5]
    end
  end

  sequence s_wr_power;
    wr_stb && addr_r == `ADDR_POWER && !soft_rst;
  endsequence
  sequence s_soft_rst_wr;
    wr_stb && addr_r == `ADDR_COMM && shift_nxt[`COMM_SOFT_RST];
  endsequence

  a_sdio_dir_gate: assert property (@(posedge clk_in) disable iff (reset_in)
    sdio_oe_out |-> $past(comm_r[`COMM_SDIO_BIDIR]))   // [R1]
    else $error("sdio driven while configured input-only");
  a_soft_rst_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    s_soft_rst_wr |=> soft_rst ##1 (dev_reset_out && power_r == 8'h00)) // [R3]
    else $error("soft reset not applied");
  a_pd_i_write: assert property (@(posedge clk_in) disable iff (reset_in)
    s_wr_power ##0 shift_nxt[`PWR_PD_I] |=> ##1 pd_i_out)   // [R4]
    else $error("I converter not powered down");
  a_pd_q_indep: assert property (@(posedge clk_in) disable iff (reset_in)
    s_wr_power ##0 (shift_nxt[`PWR_PD_Q] && !shift_nxt[`PWR_PD_I])
      |=> ##1 (pd_q_out && !pd_i_out))   // [R4]
    else $error("Q power-down not independent");
  a_pd_rx_aux: assert property (@(posedge clk_in) disable iff (reset_in)
    s_wr_power |=> ##1 (pd_rx_out == $past(shift_nxt[`PWR_PD_RX], 2) &&
                        pd_aux_out == $past(shift_nxt[`PWR_PD_AUX], 2)))  // [R5]
    else $error("receiver or aux ADC power-down wrong");
  a_binary_msb: assert property (@(posedge clk_in) disable iff (reset_in)
    (fmt_r[`FMT_BINARY] && !fmt_r[`FMT_MSB_SWAP] && fmt_r[1:0] == `FMT_W16)
      |=> data_word_out[15] == !$past(data_s[15]))   // [R6]
    else $error("binary sample msb not converted");
  a_swap_map: assert property (@(posedge clk_in) disable iff (reset_in)
    (fmt_r[`FMT_MSB_SWAP] && !fmt_r[`FMT_BINARY] && fmt_r[1:0] == `FMT_W16)
      |=> (data_word_out[0] == $past(data_s[15]) &&
           data_word_out[15] == $past(data_s[0])))   // [R8]
    else $error("input bit swap wrong");
  a_lock_lost_set: assert property (@(posedge clk_in) disable iff (reset_in)
    (ev_d_r[3] && !ev_s[3] && !soft_rst) |=> flag_r[`EV_PLL_LOST])   // [R16]
    else $error("lock lost flag not set");
  a_lock_lost_latch: assert property (@(posedge clk_in) disable iff (reset_in)
    (flag_r[`EV_PLL_LOST] && !flag_clr[`EV_PLL_LOST] && !soft_rst)
      |=> flag_r[`EV_PLL_LOST])   // [R16]
    else $error("lock lost flag not latched");
  a_irq_enabled: assert property (@(posedge clk_in) disable iff (reset_in)
    (flag_r[`EV_PLL_LOST] && ien_r[`EV_PLL_LOST]) |=> irq_out)   // [R10] [R17]
    else $error("enabled event raised no interrupt");
  a_irq_masked: assert property (@(posedge clk_in) disable iff (reset_in)
    (flag_r & ien_r) == 8'h00 |=> !irq_out)   // [R17]
    else $error("interrupt without enabled event");

endmodule

// >>> verilog/pin_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser for pins arriving from outside the clock domain
module pin_sync #(
  parameter int              WIDTH    = 1,
  parameter logic [WIDTH-1:0] INIT_VAL = '0
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      meta_r <= INIT_VAL;
      q_out  <= INIT_VAL;
    end
    else
    begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule
